// >>> shared/flgc_defines.vh
/*
 constants for the loop gain configuration register bank: register indices,
 byte addresses, field positions and reset values.
 assumes nothing beyond a verilog-2005 preprocessor.
*/
`ifndef FLGC_DEFINES_VH
`define FLGC_DEFINES_VH

// printed offsets are register indices (0x8e is not word aligned)
`define FLGC_IDX_LOOP3 8'h8c
`define FLGC_IDX_LOOP4 8'h8e
`define FLGC_IDX_CURVE1 8'h94
`define FLGC_ADDR_LOOP3 10'h230
`define FLGC_ADDR_LOOP4 10'h238
`define FLGC_ADDR_CURVE1 10'h250
`define FLGC_ADDR_W 10

// loop_config_three fields
`define FLGC_BEMF_HI 30
`define FLGC_BEMF_LO 23
`define FLGC_CKP_HI 22
`define FLGC_CKP_LO 13
`define FLGC_CKI_HI 12
`define FLGC_CKI_LO 3
`define FLGC_VKPH_HI 2
`define FLGC_VKPH_LO 0
// loop_config_four fields
`define FLGC_VKPL_HI 30
`define FLGC_VKPL_LO 24
`define FLGC_VKI_HI 23
`define FLGC_VKI_LO 14
`define FLGC_MAXS_HI 13
`define FLGC_MAXS_LO 0
// rate_curve_one fields
`define FLGC_PROF_HI 30
`define FLGC_PROF_LO 29
`define FLGC_DON_HI 28
`define FLGC_DON_LO 21
`define FLGC_DOFF_HI 20
`define FLGC_DOFF_LO 13
`define FLGC_DCLP_HI 12
`define FLGC_DCLP_LO 5
`define FLGC_DUTA_HI 4
`define FLGC_DUTA_LO 0

// bit 31 of every register is reserved and held at zero
`define FLGC_WR_MASK 32'h7fffffff
`define FLGC_RESET_VAL 32'h00000000

// speed-profile mode codes
`define FLGC_PROF_REF 2'h0
`define FLGC_PROF_LIN 2'h1
`define FLGC_PROF_STAIR 2'h2
`define FLGC_PROF_FWDREV 2'h3

// axi response codes
`define FLGC_RESP_OKAY 2'h0
`define FLGC_RESP_SLVERR 2'h2

`endif

// >>> design/flgc_regs.v
/*
 axi4-lite register bank holding motor back-emf constant, current and speed
 loop gains, maximum electrical speed and the first speed profile register.
 assumes a single 50 mhz clock, synchronous active-low reset and a master
 that keeps at most one write and one read outstanding.
*/
`timescale 1ns/1ps
`default_nettype none
`include "flgc_defines.vh"

module flgc_regs (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // write address channel
  input wire [31:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // write data channel
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // write response channel
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // read address channel
  input wire [31:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // read data channel
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // decoded configuration toward the control algorithm
  output reg [7:0] back_emf_coefficient,
  output reg [9:0] current_prop_gain,
  output reg [9:0] current_integ_gain,
  output reg current_gain_auto,
  output reg [9:0] velocity_prop_gain,
  output reg [9:0] velocity_integ_gain,
  output reg [13:0] max_speed_limit,
  output reg [1:0] profile_mode,
  output reg [3:0] profile_mode_onehot,
  output reg [7:0] turn_on_duty_first,
  output reg [7:0] turn_off_duty_first,
  output reg [7:0] clamp_duty_first,
  output reg [4:0] duty_a_upper
);

  // register select codes
  localparam SEL_NONE = 2'd0;
  localparam SEL_LOOP3 = 2'd1;
  localparam SEL_LOOP4 = 2'd2;
  localparam SEL_CURVE1 = 2'd3;

  reg [31:0] loop_config_three_reg;
  reg [31:0] loop_config_four_reg;
  reg [31:0] rate_curve_one_reg;
  reg [31:0] aw_addr_reg;
  reg aw_full_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  reg w_full_reg;
  reg [31:0] rd_word;
  reg [31:0] wr_merged;
  reg [1:0] wr_sel;
  wire wr_fire;
  wire rd_take;
  genvar gi;

  // address decode, used by both the write and the read path
  function [1:0] dec_sel;
    input [31:0] addr;
    begin
      if (addr[31:`FLGC_ADDR_W] != 22'h000000)
        dec_sel = SEL_NONE;
      else if (addr[`FLGC_ADDR_W-1:0] == `FLGC_ADDR_LOOP3)
        dec_sel = SEL_LOOP3;
      else if (addr[`FLGC_ADDR_W-1:0] == `FLGC_ADDR_LOOP4)
        dec_sel = SEL_LOOP4;
      else if (addr[`FLGC_ADDR_W-1:0] == `FLGC_ADDR_CURVE1)
        dec_sel = SEL_CURVE1;
      else
        dec_sel = SEL_NONE;
    end
  endfunction

  // address and data are taken independently; each holds until the response
  assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_full_reg && !s_axi_bvalid;
  assign wr_fire = aw_full_reg && w_full_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_take = s_axi_arvalid && !s_axi_rvalid;

  // current register word selected by the captured write address
  always @*
  begin
    wr_sel = dec_sel(aw_addr_reg);
    case (wr_sel)
      SEL_LOOP3: wr_merged = loop_config_three_reg;
      SEL_LOOP4: wr_merged = loop_config_four_reg;
      SEL_CURVE1: wr_merged = rate_curve_one_reg;
      default: wr_merged = 32'h00000000;
    endcase
  end

  // byte-lane merge; a generate loop keeps the four lanes identical
  wire [31:0] wr_lanes;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_lane
      assign wr_lanes[gi*8+7:gi*8] = w_strb_reg[gi] ? w_data_reg[gi*8+7:gi*8]
        : wr_merged[gi*8+7:gi*8];
    end
  endgenerate

  // write channel capture and response
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_addr_reg <= 32'h00000000;
      aw_full_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      w_full_reg <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `FLGC_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr_reg <= s_axi_awaddr;
        aw_full_reg <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        w_full_reg <= 1'b1;
      end
      if (wr_fire)
      begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_sel == SEL_NONE) ? `FLGC_RESP_SLVERR : `FLGC_RESP_OKAY;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // register storage; reserved bit 31 never stores a one
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      loop_config_three_reg <= `FLGC_RESET_VAL;
      loop_config_four_reg <= `FLGC_RESET_VAL;
      rate_curve_one_reg <= `FLGC_RESET_VAL;
    end
    else if (wr_fire)
    begin
      case (wr_sel)
        SEL_LOOP3: loop_config_three_reg <= wr_lanes & `FLGC_WR_MASK;
        SEL_LOOP4: loop_config_four_reg <= wr_lanes & `FLGC_WR_MASK;
        SEL_CURVE1: rate_curve_one_reg <= wr_lanes & `FLGC_WR_MASK;
        default: loop_config_three_reg <= loop_config_three_reg;
      endcase
    end
  end

  // read mux; unmapped addresses read zero with slverr
  always @*
  begin
    case (dec_sel(s_axi_araddr))
      SEL_LOOP3: rd_word = loop_config_three_reg;
      SEL_LOOP4: rd_word = loop_config_four_reg;
      SEL_CURVE1: rd_word = rate_curve_one_reg;
      default: rd_word = 32'h00000000;
    endcase
  end

  // read data channel, answer one cycle after the address is taken
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `FLGC_RESP_OKAY;
    end
    else if (rd_take)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= (dec_sel(s_axi_araddr) == SEL_NONE) ? `FLGC_RESP_SLVERR
        : `FLGC_RESP_OKAY;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // decoded fields are registered so the consumer sees glitch-free values
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      back_emf_coefficient <= 8'h00;
      current_prop_gain <= 10'h000;
      current_integ_gain <= 10'h000;
      current_gain_auto <= 1'b1;
      velocity_prop_gain <= 10'h000;
      velocity_integ_gain <= 10'h000;
      max_speed_limit <= 14'h0000;
      profile_mode <= `FLGC_PROF_REF;
      profile_mode_onehot <= 4'h1;
      turn_on_duty_first <= 8'h00;
      turn_off_duty_first <= 8'h00;
      clamp_duty_first <= 8'h00;
      duty_a_upper <= 5'h00;
    end
    else
    begin
      back_emf_coefficient <= loop_config_three_reg[`FLGC_BEMF_HI:`FLGC_BEMF_LO];
      // one gain pair feeds both d and q loops, so only one value is exported
      current_prop_gain <= loop_config_three_reg[`FLGC_CKP_HI:`FLGC_CKP_LO];
      current_integ_gain <= loop_config_three_reg[`FLGC_CKI_HI:`FLGC_CKI_LO];
      // both fields zero hands the current loop gains to the auto-tuner
      current_gain_auto <= (loop_config_three_reg[`FLGC_CKP_HI:`FLGC_CKI_LO]
        == 20'h00000);
      velocity_prop_gain <= {loop_config_three_reg[`FLGC_VKPH_HI:`FLGC_VKPH_LO],
        loop_config_four_reg[`FLGC_VKPL_HI:`FLGC_VKPL_LO]};
      velocity_integ_gain <= loop_config_four_reg[`FLGC_VKI_HI:`FLGC_VKI_LO];
      max_speed_limit <= loop_config_four_reg[`FLGC_MAXS_HI:`FLGC_MAXS_LO];
      profile_mode <= rate_curve_one_reg[`FLGC_PROF_HI:`FLGC_PROF_LO];
      case (rate_curve_one_reg[`FLGC_PROF_HI:`FLGC_PROF_LO])
        `FLGC_PROF_REF: profile_mode_onehot <= 4'h1;
        `FLGC_PROF_LIN: profile_mode_onehot <= 4'h2;
        `FLGC_PROF_STAIR: profile_mode_onehot <= 4'h4;
        `FLGC_PROF_FWDREV: profile_mode_onehot <= 4'h8;
        default: profile_mode_onehot <= 4'h1;
      endcase
      turn_on_duty_first <= rate_curve_one_reg[`FLGC_DON_HI:`FLGC_DON_LO];
      turn_off_duty_first <= rate_curve_one_reg[`FLGC_DOFF_HI:`FLGC_DOFF_LO];
      clamp_duty_first <= rate_curve_one_reg[`FLGC_DCLP_HI:`FLGC_DCLP_LO];
      duty_a_upper <= rate_curve_one_reg[`FLGC_DUTA_HI:`FLGC_DUTA_LO];
    end
  end

endmodule // flgc_regs
`default_nettype wire

// >>> test/flgc_regs_properties.sv
/*
 checker for flgc_regs: bus handshake timing and decoded output relations.
 assumes the single aclk domain with synchronous active-low aresetn.
*/
`timescale 1ns/1ps
`default_nettype none
`include "flgc_defines.vh"
module flgc_properties (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // write side
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  // read side
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // decoded fields
  input wire [9:0] current_prop_gain,
  input wire [9:0] current_integ_gain,
  input wire current_gain_auto,
  input wire [1:0] profile_mode,
  input wire [3:0] profile_mode_onehot
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_auto_flag: assert property (current_gain_auto ==
    (current_prop_gain == 10'h0 && current_integ_gain == 10'h0)) else $error("auto flag wrong");
  a_mode_onehot: assert property (profile_mode_onehot == (4'h1 << profile_mode))
    else $error("mode one-hot wrong");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
  a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken early");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write answer late");
  a_unmapped_rd: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[31:10] != 0
    |=> s_axi_rresp == `FLGC_RESP_SLVERR && s_axi_rdata == 0) else $error("unmapped read");
endmodule // flgc_properties
bind flgc_regs flgc_properties u_chk (.*);
`default_nettype wire

// >>> test/tb.sv
/*
 self-checking bench for flgc_regs: corner and random register traffic.
 assumes flgc_defines.vh on the include path and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
`include "flgc_defines.vh"
module tb;
  // bus drive, design outputs and bench state
  logic aclk = 0;
  logic aresetn = 0;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, seed = 32'h0ddb, d, m[3];
  logic [3:0] s_axi_wstrb = 0;
  logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, current_gain_auto;
  wire [1:0] s_axi_bresp, s_axi_rresp, profile_mode;
  wire [31:0] s_axi_rdata;
  wire [7:0] back_emf_coefficient, turn_on_duty_first, turn_off_duty_first, clamp_duty_first;
  wire [9:0] current_prop_gain, current_integ_gain, velocity_prop_gain, velocity_integ_gain;
  wire [13:0] max_speed_limit;
  wire [3:0] profile_mode_onehot;
  wire [4:0] duty_a_upper;
  logic [1:0] r;
  int mismatches = 0, cmp_count = 0, i, k;
  flgc_regs dut (.*);
  // 50 mhz clock
  always #10 aclk = ~aclk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // byte lanes merge, bit 31 never stored
  function automatic logic [31:0] merge(logic [31:0] o, n, logic [3:0] s);
    for (int b = 0; b < 4; b++)
      if (s[b]) o[b*8+:8] = n[b*8+:8];
    return o & `FLGC_WR_MASK;
  endfunction
  function automatic logic [31:0] adr(int x);
    return 32'(x == 0 ? `FLGC_ADDR_LOOP3 : x == 1 ? `FLGC_ADDR_LOOP4 : `FLGC_ADDR_CURVE1);
  endfunction
  task automatic chk(logic [31:0] g, e);
    cmp_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("FAIL %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic close_out();
    if (mismatches == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic stall();
    mismatches++;
    $display("FAIL %0t no answer", $time);
    close_out();
  endtask
  // write: address and data offered together, each released once taken
  // handshakes are judged on settled mid-cycle values, the edge only acts on them
  task automatic wr(logic [31:0] a, v, logic [3:0] s);
    logic aw_hit, w_hit, b_hit;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    b_hit = 0;
    for (k = 0; k < 20 && !b_hit; k++)
    begin
      @(negedge aclk);
      aw_hit = s_axi_awvalid && s_axi_awready;
      w_hit = s_axi_wvalid && s_axi_wready;
      b_hit = s_axi_bvalid === 1 && s_axi_bready;
      r = s_axi_bresp;
      @(posedge aclk);
      if (aw_hit) s_axi_awvalid <= 0;
      if (w_hit) s_axi_wvalid <= 0;
      if (b_hit) s_axi_bready <= 0;
    end
    if (!b_hit) stall();
  endtask
  task automatic rd(logic [31:0] a);
    logic ar_hit, r_hit;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    r_hit = 0;
    for (k = 0; k < 20 && !r_hit; k++)
    begin
      @(negedge aclk);
      ar_hit = s_axi_arvalid && s_axi_arready;
      r_hit = s_axi_rvalid === 1 && s_axi_rready;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ar_hit) s_axi_arvalid <= 0;
      if (r_hit) s_axi_rready <= 0;
    end
    if (!r_hit) stall();
  endtask
  // decoded outputs settle one edge after the store, so look at the falling edge
  task automatic dec();
    @(negedge aclk);
    chk({back_emf_coefficient, current_prop_gain, current_integ_gain, velocity_prop_gain[9:7]}, m[0]);
    chk({velocity_prop_gain[6:0], velocity_integ_gain, max_speed_limit}, m[1]);
    chk(velocity_prop_gain, {m[0][2:0], m[1][30:24]});
    chk({profile_mode, turn_on_duty_first, turn_off_duty_first, clamp_duty_first, duty_a_upper}, m[2]);
    chk({profile_mode_onehot, current_gain_auto}, {4'h1 << m[2][30:29], m[0][22:3] == 0});
  endtask
  task automatic wm(int x, logic [31:0] v, logic [3:0] s);
    wr(adr(x), v, s);
    chk(r, `FLGC_RESP_OKAY);
    m[x] = merge(m[x], v, s);
    dec();
    rd(adr(x));
    chk(d, m[x]);
  endtask
  // main sequence: reset state, corners, every mode, random traffic, unmapped
  initial
  begin
    m = '{default: 0};
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    dec();
    wm(0, 32'hff800007, 4'hf); // zero current gains, bit 31 dropped
    wm(0, 32'h00002000, 4'h2); // lone kp bit
    wm(0, 32'h00000008, 4'h1); // ki bit set beside the kept kp bit
    wm(1, 32'hffffffff, 4'hf);
    for (i = 0; i < 4; i++)
    begin
      d = rnd();
      wm(2, {1'b0, i[1:0], d[28:0]}, 4'hf);
    end
    for (i = 0; i < 40; i++)
    begin
      d = rnd();
      wm(d[1:0] % 3, rnd(), d[7:4] | 4'h1);
    end
    wr(32'h234, rnd(), 4'hf);
    chk(r, `FLGC_RESP_SLVERR);
    dec();
    rd(32'h400);
    chk({d[29:0], r}, `FLGC_RESP_SLVERR);
    close_out();
  end
endmodule // tb
`default_nettype wire
